//--- rtl/id_memory.sv
// serial id and diagnostic byte memory with registered read data
`timescale 1ns/100ps
`include "optmod_defines.svh"
module id_memory
  import optmod_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // access
  mem_if.slave      port,
  // live diagnostic values
  input  wire word_t diag_word [0:4],
  input  wire byte_t status_byte
);
  byte_t id_mem   [0:255];
  byte_t user_mem [0:255];
  byte_t next_rdata;

  always_comb
  begin
    next_rdata = id_mem[port.addr];
    if (port.rd_sel_diag)
    begin
      case (port.addr)
        `DIAG_TEMP:        next_rdata = diag_word[0][15:8];
        `DIAG_TEMP + 8'h01:  next_rdata = diag_word[0][7:0];
        `DIAG_VCC:         next_rdata = diag_word[1][15:8];
        `DIAG_VCC + 8'h01:   next_rdata = diag_word[1][7:0];
        `DIAG_BIAS:        next_rdata = diag_word[2][15:8];
        `DIAG_BIAS + 8'h01:  next_rdata = diag_word[2][7:0];
        `DIAG_TXPWR:       next_rdata = diag_word[3][15:8];
        `DIAG_TXPWR + 8'h01: next_rdata = diag_word[3][7:0];
        `DIAG_RXPWR:       next_rdata = diag_word[4][15:8];
        `DIAG_RXPWR + 8'h01: next_rdata = diag_word[4][7:0];
        `DIAG_STATUS:      next_rdata = status_byte;
        default:           next_rdata = user_mem[port.addr];
      endcase
    end
  end

  // id area is host writable here; a production part would lock it
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      port.rdata <= 8'h00;
    else
      port.rdata <= next_rdata;
    if (port.wr_en && !port.rd_sel_diag)
      id_mem[port.addr] <= port.wdata;
    if (port.wr_en && port.rd_sel_diag)
      user_mem[port.addr] <= port.wdata;
  end
endmodule : id_memory

//--- rtl/mem_if.sv
// byte memory access carrier between the serial slave and the memories
`timescale 1ns/100ps
interface mem_if;
  import optmod_pkg::*;
  logic  rd_sel_diag;
  logic  [7:0] addr;
  byte_t rdata;
  logic  wr_en;
  byte_t wdata;
  modport master (output rd_sel_diag, output addr, input rdata, output wr_en, output wdata);
  modport slave  (input rd_sel_diag, input addr, output rdata, input wr_en, input wdata);
endinterface : mem_if

//--- rtl/optical_module_control_status.sv
// low-speed control and status logic of the pluggable optical module
//
// Function
// - laser back on within 1 ms
// - laser off within 10 us of disable
// - init including fault clear within 300 ms
// - fault flag raised within 100 us
// - fault flag low normally, high on fault
// - transmit on low; high or open disables
// - signal-lost flag high while signal lost
// - presence pin tied to ground
// - id clock and data form two-wire bus
// - serial bus returns id and diagnostics
// - monitor five values, internal or external calibration
`timescale 1ns/100ps
`include "optmod_defines.svh"
module optical_module_control_status
  import optmod_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = `CYC_INIT_MAX,
  parameter int unsigned ON_CYCLES   = `CYC_ON_MAX
)
(
  // clock and reset
  input  wire logic  clk_sys,
  input  wire logic  reset_n,
  // host pins
  input  wire logic  transmit_off_input,
  output logic       fault_flag_o,
  output logic       fault_flag_oe,
  output logic       signal_lost_flag_o,
  output logic       signal_lost_flag_oe,
  output logic       present_o,
  output logic       present_oe,
  input  wire logic  id_clk_i,
  output logic       id_clk_o,
  output logic       id_clk_oe,
  input  wire logic  id_data_i,
  output logic       id_data_o,
  output logic       id_data_oe,
  // analog front end status
  input  wire logic  laser_fault_raw,
  input  wire logic  rx_signal_lost_raw,
  // monitor raw readings
  input  wire word_t mon_temp,
  input  wire word_t mon_vcc,
  input  wire word_t mon_bias,
  input  wire word_t mon_txpwr,
  input  wire word_t mon_rxpwr,
  input  wire word_t cal_gain,
  input  wire word_t cal_offset,
  input  wire logic  cal_external,
  // laser drive
  output logic       laser_enable,
  output logic       init_done
);
  import optmod_pkg::*;

  ////////////////////////////////////////////////////////////////
  typedef enum {M_INIT, M_OFF, M_WAKE, M_ON, M_FAULT} mode_t;
  mode_t       mode, next_mode;
  logic [31:0] tmr, next_tmr;
  logic [31:0] offcnt, next_offcnt;
  logic        fault, next_fault;
  logic        lost, next_lost;
  logic        next_laser_enable;
  logic [1:0]  txoff_s, flt_s, los_s, scl_s, sda_s;
  word_t       diag_word [0:4];
  byte_t       status_byte;
  logic        sda_pull;

  // two-flop synchronisers for every pin-side input
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      txoff_s <= 2'h3; flt_s <= 2'h0; los_s <= 2'h3; scl_s <= 2'h3; sda_s <= 2'h3;
    end
    else
    begin
      txoff_s <= {txoff_s[0], transmit_off_input};
      flt_s   <= {flt_s[0], laser_fault_raw};
      los_s   <= {los_s[0], rx_signal_lost_raw};
      scl_s   <= {scl_s[0], id_clk_i};
      sda_s   <= {sda_s[0], id_data_i};
    end
  end

  ////////////////////////////////////////////////////////////////
  // transmit control; synchroniser costs two cycles, well inside both limits
  always_comb
  begin
    next_mode = mode;
    next_tmr = tmr;
    next_fault = fault;
    next_offcnt = txoff_s[1] ? offcnt + 32'h1 : 32'h0;
    case (mode)
      M_INIT:
      begin
        next_fault = 1'b0;
        next_tmr = tmr + 32'h1;
        if (tmr >= INIT_CYCLES - 1)
          next_mode = txoff_s[1] ? M_OFF : M_WAKE;
      end
      M_OFF:
        if (!txoff_s[1])
        begin
          next_mode = M_WAKE; next_tmr = 32'h0;
        end
      M_WAKE:
      begin
        next_tmr = tmr + 32'h1;
        if (txoff_s[1])
          next_mode = M_OFF;
        else if (tmr >= ON_CYCLES - 1 || tmr >= 32'h1)
          next_mode = M_ON;
      end
      M_ON:
        if (txoff_s[1])
          next_mode = M_OFF;
      M_FAULT:
        // a disable pulse of the minimum width restarts initialisation
        if (!txoff_s[1] && offcnt >= `CYC_RESET_MIN)
        begin
          next_mode = M_INIT; next_tmr = 32'h0;
        end
      default: next_mode = M_INIT;
    endcase
    if (flt_s[1] && mode != M_INIT && mode != M_FAULT)
    begin
      next_fault = 1'b1;
      next_mode = M_FAULT;
    end
  end

  assign next_laser_enable = (next_mode == M_ON);

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      mode <= M_INIT; tmr <= 32'h0; fault <= 1'b0; offcnt <= 32'h0; laser_enable <= 1'b0;
    end
    else
    begin
      mode <= next_mode; tmr <= next_tmr; fault <= next_fault;
      offcnt <= next_offcnt; laser_enable <= next_laser_enable;
    end
  end

  ////////////////////////////////////////////////////////////////
  // signal-lost follows the synchronised detector directly
  always_comb
    next_lost = los_s[1];

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      lost <= 1'b1;
    else
      lost <= next_lost;
  end

  // open collector: drive low when clear, release when set
  assign fault_flag_o        = 1'b0;
  assign fault_flag_oe       = !fault;
  assign signal_lost_flag_o  = 1'b0;
  assign signal_lost_flag_oe = !lost;
  assign present_o           = 1'b0;
  assign present_oe          = 1'b1;
  assign init_done           = (mode != M_INIT);

  ////////////////////////////////////////////////////////////////
  // calibration: external mode applies gain (8.8) and offset
  function automatic word_t calibrate(input word_t raw, input word_t g, input word_t o, input logic ext);
    logic [31:0] prod;
    prod = raw * g;
    calibrate = ext ? word_t'(prod[23:8] + o) : raw;
  endfunction : calibrate

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < 5; i++)
        diag_word[i] <= 16'h0000;
    end
    else
    begin
      diag_word[0] <= calibrate(mon_temp, cal_gain, cal_offset, cal_external);
      diag_word[1] <= calibrate(mon_vcc, cal_gain, cal_offset, cal_external);
      diag_word[2] <= calibrate(mon_bias, cal_gain, cal_offset, cal_external);
      diag_word[3] <= calibrate(mon_txpwr, cal_gain, cal_offset, cal_external);
      diag_word[4] <= calibrate(mon_rxpwr, cal_gain, cal_offset, cal_external);
    end
  end

  assign status_byte = {txoff_s[1], 2'h0, cal_external, 1'b0, fault, lost, init_done};

  ////////////////////////////////////////////////////////////////
  mem_if mbus ();

  serial_slave u_slave (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .scl     (scl_s[1]),
    .sda     (sda_s[1]),
    .sda_oe  (sda_pull),
    .mem     (mbus.master)
  );

  id_memory u_mem (
    .clk_sys     (clk_sys),
    .reset_n     (reset_n),
    .port        (mbus.slave),
    .diag_word   (diag_word),
    .status_byte (status_byte)
  );

  assign id_clk_o   = 1'b0;
  assign id_clk_oe  = 1'b0;
  assign id_data_o  = 1'b0;
  assign id_data_oe = sda_pull;
endmodule : optical_module_control_status

//--- rtl/optmod_defines.svh
// timing and memory constants for the optical module control block
`ifndef OPTMOD_DEFINES_SVH
`define OPTMOD_DEFINES_SVH

`define CLK_PERIOD_NS        50
`define T_ON_MAX_MS          1
`define T_OFF_MAX_US         10
`define T_INIT_MAX_MS        300
`define T_FAULT_MAX_US       100
`define T_RESET_MIN_US       10
`define T_LOSS_MAX_US        100
`define F_SERIAL_MAX_KHZ     400

`define CYC_ON_MAX           ((`T_ON_MAX_MS * 1000000) / `CLK_PERIOD_NS)
`define CYC_OFF_MAX          ((`T_OFF_MAX_US * 1000) / `CLK_PERIOD_NS)
`define CYC_INIT_MAX         ((`T_INIT_MAX_MS * 1000000) / `CLK_PERIOD_NS)
`define CYC_FAULT_MAX        ((`T_FAULT_MAX_US * 1000) / `CLK_PERIOD_NS)
`define CYC_RESET_MIN        ((`T_RESET_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_LOSS_MAX         ((`T_LOSS_MAX_US * 1000) / `CLK_PERIOD_NS)

`define DEV_ADDR_ID          7'h50
`define DEV_ADDR_DIAG        7'h51
`define DIAG_TEMP            8'h60
`define DIAG_VCC             8'h62
`define DIAG_BIAS            8'h64
`define DIAG_TXPWR           8'h66
`define DIAG_RXPWR           8'h68
`define DIAG_STATUS          8'h6E
`define DIAG_CAL_EXT_BIT     8'h5C
`define ST_TXOFF_BIT         7
`define ST_FAULT_BIT         2
`define ST_LOST_BIT          1
`define CAL_EXT_MASK         8'h10

`endif

//--- rtl/optmod_pkg.sv
// types shared by the optical module control block
package optmod_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [15:0] word_t;
  typedef enum logic [1:0] {CAL_INTERNAL, CAL_EXTERNAL} cal_mode_t;
endpackage : optmod_pkg

//--- rtl/serial_slave.sv
// two-wire serial slave, byte-addressed, two device addresses
`timescale 1ns/100ps
`include "optmod_defines.svh"
module serial_slave
  import optmod_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // synchronised bus levels
  input  wire logic scl,
  input  wire logic sda,
  output logic      sda_oe,
  // memory side
  mem_if.master     mem
);
  typedef enum {S_IDLE, S_DEVADDR, S_ACK_DEV, S_WORDADDR, S_ACK_WA, S_WDATA, S_ACK_WD, S_RDATA, S_RACK} st_t;
  st_t   state, next_state;
  logic  scl_d, sda_d, next_sda_oe;
  logic  [3:0] bitcnt, next_bitcnt;
  byte_t shreg, next_shreg;
  logic  [7:0] ptr, next_ptr;
  logic  sel, next_sel, rd, next_rd;
  logic  scl_rise, scl_fall, start_c, stop_c;

  assign scl_rise = scl && !scl_d;
  assign scl_fall = !scl && scl_d;
  assign start_c  = scl && scl_d && sda_d && !sda;
  assign stop_c   = scl && scl_d && !sda_d && sda;
  assign mem.addr = ptr;
  assign mem.rd_sel_diag = sel;
  assign mem.wdata = shreg;
  assign mem.wr_en = (state == S_WDATA) && scl_fall && (bitcnt == 4'h8);

  always_comb
  begin
    next_state = state; next_bitcnt = bitcnt; next_shreg = shreg;
    next_ptr = ptr; next_sel = sel; next_rd = rd; next_sda_oe = sda_oe;
    if (stop_c)
    begin
      next_state = S_IDLE; next_sda_oe = 1'b0;
    end
    else if (start_c)
    begin
      next_state = S_DEVADDR; next_bitcnt = 4'h0; next_sda_oe = 1'b0;
    end
    else
    begin
      case (state)
        S_IDLE: next_sda_oe = 1'b0;
        S_DEVADDR, S_WORDADDR, S_WDATA:
        begin
          if (scl_rise)
          begin
            next_shreg = {shreg[6:0], sda};
            next_bitcnt = bitcnt + 4'h1;
          end
          if (scl_fall && bitcnt == 4'h8)
          begin
            next_bitcnt = 4'h0;
            if (state == S_DEVADDR)
            begin
              if (shreg[7:1] == `DEV_ADDR_ID || shreg[7:1] == `DEV_ADDR_DIAG)
              begin
                next_sel = shreg[1]; next_rd = shreg[0];
                next_sda_oe = 1'b1; next_state = S_ACK_DEV;
              end
              else
                next_state = S_IDLE;
            end
            else if (state == S_WORDADDR)
            begin
              next_ptr = shreg; next_sda_oe = 1'b1; next_state = S_ACK_WA;
            end
            else
            begin
              next_ptr = ptr + 8'h01; next_sda_oe = 1'b1; next_state = S_ACK_WD;
            end
          end
        end
        S_ACK_DEV, S_ACK_WA, S_ACK_WD:
          if (scl_fall)
          begin
            if (state == S_ACK_DEV && rd)
            begin
              next_state = S_RDATA; next_shreg = mem.rdata;
              next_sda_oe = !mem.rdata[7]; next_bitcnt = 4'h1;
            end
            else
            begin
              next_sda_oe = 1'b0;
              next_state = (state == S_ACK_DEV) ? S_WORDADDR : S_WDATA;
            end
          end
        S_RDATA:
          if (scl_fall)
          begin
            if (bitcnt == 4'h8)
            begin
              next_sda_oe = 1'b0; next_state = S_RACK; next_ptr = ptr + 8'h01;
            end
            else
            begin
              next_shreg = {shreg[6:0], 1'b0};
              next_sda_oe = !shreg[6];
              next_bitcnt = bitcnt + 4'h1;
            end
          end
        S_RACK:
          if (scl_rise)
            next_state = sda ? S_IDLE : S_ACK_DEV; // nack ends the read
        default: next_state = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      state <= S_IDLE; bitcnt <= 4'h0; shreg <= 8'h00; ptr <= 8'h00;
      sel <= 1'b0; rd <= 1'b0; sda_oe <= 1'b0; scl_d <= 1'b1; sda_d <= 1'b1;
    end
    else
    begin
      state <= next_state; bitcnt <= next_bitcnt; shreg <= next_shreg; ptr <= next_ptr;
      sel <= next_sel; rd <= next_rd; sda_oe <= next_sda_oe; scl_d <= scl; sda_d <= sda;
    end
  end
endmodule : serial_slave

//--- verif/host_board_model.sv
// host board: pull-ups on the module pins and an idle two-wire master
`timescale 1ns/100ps
module host_board_model
(
  // module pins
  input  wire logic fault_flag_o,
  input  wire logic fault_flag_oe,
  input  wire logic signal_lost_flag_o,
  input  wire logic signal_lost_flag_oe,
  input  wire logic present_o,
  input  wire logic present_oe,
  input  wire logic id_clk_o,
  input  wire logic id_clk_oe,
  input  wire logic id_data_o,
  input  wire logic id_data_oe,
  // host controls and resolved levels
  input  wire logic tx_drive,
  input  wire logic tx_val,
  input  wire logic scl_low,
  input  wire logic sda_low,
  output logic      fault_line,
  output logic      lost_line,
  output logic      present_line,
  output logic      scl,
  output logic      sda,
  output logic      tx_pin
);
  assign fault_line   = fault_flag_oe ? fault_flag_o : 1'h1;
  assign lost_line    = signal_lost_flag_oe ? signal_lost_flag_o : 1'h1;
  assign present_line = present_oe ? present_o : 1'h1;
  // wired-and: the bench master and the module can only pull a line low
  assign scl          = (scl_low || (id_clk_oe && !id_clk_o)) ? 1'h0 : 1'h1;
  assign sda          = (sda_low || (id_data_oe && !id_data_o)) ? 1'h0 : 1'h1;
  // an undriven disable pin reads high through the pull-up
  assign tx_pin       = tx_drive ? tx_val : 1'h1;
endmodule : host_board_model

//--- verif/optical_module_control_status_assertions.sv
// port-level concurrent checks for the optical module control block
`timescale 1ns/100ps
`include "optmod_defines.svh"
module optmod_checker
#(
  parameter int unsigned INIT_CYCLES = 100
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // pins and status
  input wire logic transmit_off_input,
  input wire logic fault_flag_o,
  input wire logic fault_flag_oe,
  input wire logic signal_lost_flag_o,
  input wire logic signal_lost_flag_oe,
  input wire logic present_o,
  input wire logic present_oe,
  input wire logic id_clk_oe,
  input wire logic laser_fault_raw,
  input wire logic rx_signal_lost_raw,
  input wire logic laser_enable,
  input wire logic init_done
);
  logic [7:0]  hi_run;
  logic [7:0]  last_run;
  logic [3:0]  up;
  logic [31:0] wait_init;
  logic [7:0]  next_hi_run;
  logic [7:0]  next_last_run;
  logic [3:0]  next_up;
  logic [31:0] next_wait_init;
  //////////////////////////////////////////////////////////////////////////////
  // last disable-pulse length, settle time after reset, init duration
  always_comb
  begin
    next_hi_run    = transmit_off_input ? ((hi_run == 8'hFF) ? hi_run : hi_run + 8'h01) : 8'h00;
    next_last_run  = (!transmit_off_input && hi_run != 8'h00) ? hi_run : last_run;
    next_up        = (up == 4'hF) ? up : up + 4'h1;
    next_wait_init = init_done ? 32'h0 : wait_init + 32'h1;
  end
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      hi_run    <= 8'h00;
      last_run  <= 8'h00;
      up        <= 4'h0;
      wait_init <= 32'h0;
    end
    else
    begin
      hi_run    <= next_hi_run;
      last_run  <= next_last_run;
      up        <= next_up;
      wait_init <= next_wait_init;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_tx_off; transmit_off_input [*5] |-> !laser_enable; endproperty
  a_tx_off: assert property (p_tx_off) else $error("laser on while disabled");
  property p_tx_on;
    (!transmit_off_input && !laser_fault_raw && fault_flag_oe && init_done) [*8] |-> laser_enable;
  endproperty
  a_tx_on: assert property (p_tx_on) else $error("laser not restored");
  property p_init; wait_init <= INIT_CYCLES + 8; endproperty
  a_init: assert property (p_init) else $error("init too long");
  property p_init_off; !init_done |-> !laser_enable; endproperty
  a_init_off: assert property (p_init_off) else $error("laser on during init");
  property p_fault; (laser_fault_raw && init_done) [*6] |-> !fault_flag_oe; endproperty
  a_fault: assert property (p_fault) else $error("fault flag late");
  property p_lost_on; (rx_signal_lost_raw && up == 4'hF) [*5] |-> !signal_lost_flag_oe; endproperty
  a_lost_on: assert property (p_lost_on) else $error("lost flag late");
  property p_lost_off; (!rx_signal_lost_raw && up == 4'hF) [*5] |-> signal_lost_flag_oe; endproperty
  a_lost_off: assert property (p_lost_off) else $error("lost flag stuck");
  property p_pins; fault_flag_o == 1'h0 && signal_lost_flag_o == 1'h0 && present_o == 1'h0; endproperty
  a_pins: assert property (p_pins) else $error("open-collector drives high");
  property p_present; present_oe && !id_clk_oe; endproperty
  a_present: assert property (p_present) else $error("presence or clock pin wrong");
  property p_latch; (!transmit_off_input) [*6] ##0 !fault_flag_oe |=> !fault_flag_oe; endproperty
  a_latch: assert property (p_latch) else $error("fault cleared without pulse");
  property p_clear; $rose(fault_flag_oe) |-> last_run >= `CYC_RESET_MIN; endproperty
  a_clear: assert property (p_clear) else $error("fault cleared by short pulse");
  c_fault: cover property (!fault_flag_oe);
  c_clear: cover property ($rose(fault_flag_oe));
  c_lost: cover property ($fell(signal_lost_flag_oe));
  c_laser: cover property ($rose(laser_enable));
endmodule : optmod_checker

bind optical_module_control_status optmod_checker #(.INIT_CYCLES(INIT_CYCLES)) u_checker (
  .clk_sys(clk_sys), .reset_n(reset_n), .transmit_off_input(transmit_off_input),
  .fault_flag_o(fault_flag_o), .fault_flag_oe(fault_flag_oe), .signal_lost_flag_o(signal_lost_flag_o),
  .signal_lost_flag_oe(signal_lost_flag_oe), .present_o(present_o), .present_oe(present_oe),
  .id_clk_oe(id_clk_oe), .laser_fault_raw(laser_fault_raw), .rx_signal_lost_raw(rx_signal_lost_raw),
  .laser_enable(laser_enable), .init_done(init_done));

//--- verif/optical_module_control_status_tb_top.sv
// self-checking bench for the optical module control block
`timescale 1ns/100ps
`include "optmod_defines.svh"
module optical_module_control_status_tb_top;
  import optmod_pkg::*;
  localparam int unsigned INIT = 100;
  logic  clk_sys, reset_n, fault_raw, lost_raw, cal_ext, tx_drive, tx_val;
  word_t mon [0:6];
  logic  f_o, f_oe, l_o, l_oe, p_o, p_oe, c_o, c_oe, d_o, d_oe, laser_enable, init_done;
  logic  fault_line, lost_line, present_line, scl, sda, tx_pin;
  logic  scl_low, sda_low, ack;
  byte_t rx;
  word_t got;
  int    err_count, samples_checked, i;

  optical_module_control_status #(.INIT_CYCLES(INIT)) DUT (
    .clk_sys(clk_sys), .reset_n(reset_n), .transmit_off_input(tx_pin),
    .fault_flag_o(f_o), .fault_flag_oe(f_oe), .signal_lost_flag_o(l_o), .signal_lost_flag_oe(l_oe),
    .present_o(p_o), .present_oe(p_oe), .id_clk_i(scl), .id_clk_o(c_o), .id_clk_oe(c_oe),
    .id_data_i(sda), .id_data_o(d_o), .id_data_oe(d_oe), .laser_fault_raw(fault_raw),
    .rx_signal_lost_raw(lost_raw), .mon_temp(mon[0]), .mon_vcc(mon[1]), .mon_bias(mon[2]),
    .mon_txpwr(mon[3]), .mon_rxpwr(mon[4]), .cal_gain(mon[5]), .cal_offset(mon[6]),
    .cal_external(cal_ext), .laser_enable(laser_enable), .init_done(init_done));

  host_board_model host (
    .fault_flag_o(f_o), .fault_flag_oe(f_oe), .signal_lost_flag_o(l_o), .signal_lost_flag_oe(l_oe),
    .present_o(p_o), .present_oe(p_oe), .id_clk_o(c_o), .id_clk_oe(c_oe), .id_data_o(d_o),
    .id_data_oe(d_oe), .tx_drive(tx_drive), .tx_val(tx_val), .scl_low(scl_low), .sda_low(sda_low),
    .fault_line(fault_line),
    .lost_line(lost_line), .present_line(present_line), .scl(scl), .sda(sda), .tx_pin(tx_pin));

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic exp_laser(input logic off, input logic fault);
    return !off && !fault;
  endfunction : exp_laser

  // gain is 8.8 fixed point; the offset is added after scaling
  function automatic word_t exp_diag(input word_t raw, input word_t gain, input word_t offs, input logic ext);
    logic [31:0] scaled;
    scaled = ({16'h0000, raw} * {16'h0000, gain}) >> 8;
    return ext ? scaled[15:0] + offs : raw;
  endfunction : exp_diag

  function automatic logic pick(input int s);
    case (s)
      0: return fault_line;
      1: return lost_line;
      2: return laser_enable;
      default: return init_done;
    endcase
  endfunction : pick

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // quarter bit of 15 clocks: 3 us a bit keeps the master below the rate limit
  task automatic tw_quarter();
    repeat (15) @(negedge clk_sys);
  endtask : tw_quarter

  task automatic tw_bit(input logic b, output logic seen);
    sda_low = !b;
    tw_quarter();
    scl_low = 1'h0;
    tw_quarter();
    seen = sda;
    tw_quarter();
    scl_low = 1'h1;
    tw_quarter();
  endtask : tw_bit

  // serves as repeated start too: both lines go high, then data falls under a high clock
  task automatic tw_start();
    sda_low = 1'h0;
    tw_quarter();
    scl_low = 1'h0;
    tw_quarter();
    sda_low = 1'h1;
    tw_quarter();
    scl_low = 1'h1;
    tw_quarter();
  endtask : tw_start

  task automatic tw_stop();
    sda_low = 1'h1;
    tw_quarter();
    scl_low = 1'h0;
    tw_quarter();
    sda_low = 1'h0;
    tw_quarter();
  endtask : tw_stop

  // eight data bits then the acknowledge bit; sending all ones lets the module drive
  task automatic tw_byte(input byte_t tx, input logic last, output byte_t rxd, output logic acked);
    for (int j = 7; j >= 0; j--)
      tw_bit(tx[j], rxd[j]);
    tw_bit(last, acked);
  endtask : tw_byte

  // polls against the documented worst-case time, not a fixed wait
  task automatic await(input int s, input logic v, input int lim, input string nm);
    int n;
    n = 0;
    while (pick(s) !== v && n < lim)
    begin
      @(negedge clk_sys);
      n++;
    end
    check(nm, pick(s), v);
  endtask : await

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end

  initial
  begin
    repeat (60000) @(posedge clk_sys);
    err_count++;
    final_report();
  end

  initial
  begin
    err_count = 0;
    samples_checked = 0;
    void'($urandom(32'hCEB6E612));
    reset_n = 1'h0;
    {fault_raw, lost_raw, cal_ext, tx_drive, tx_val} = 5'h03;
    {scl_low, sda_low} = 2'h0;
    for (i = 0; i < 7; i++) mon[i] = 16'h0000;
    repeat (2) @(negedge clk_sys);
    reset_n = 1'h1;
    await(3, 1'h1, INIT + 20, "init_done");
    check("present", present_line, 1'h0);
    check("fault_idle", fault_line, 1'h0);
    check("sda_idle", sda, 1'h1);
    check("laser_disabled", laser_enable, exp_laser(1'h1, 1'h0));
    // even passes release the pin to its pull-up instead of driving it high
    for (i = 0; i < 6; i++)
    begin
      for (int k = 0; k < 7; k++) mon[k] = 16'($urandom);
      cal_ext = 1'($urandom_range(0, 1));
      tx_val = 1'h0;
      await(2, exp_laser(1'h0, 1'h0), 20000, "laser_on");
      repeat ($urandom_range(1, 30)) @(negedge clk_sys);
      tx_drive = i[0];
      tx_val = 1'h1;
      await(2, exp_laser(1'h1, 1'h0), 200, "laser_off");
      tx_drive = 1'h1;
    end
    // one diagnostic word in each calibration mode over the two-wire bus
    for (i = 0; i < 2; i++)
    begin
      cal_ext = i[0];
      tw_start();
      tw_byte({`DEV_ADDR_DIAG, 1'h0}, 1'h1, rx, ack);
      check("ack_dev", ack, 1'h0);
      tw_byte(i[0] ? `DIAG_RXPWR : `DIAG_TEMP, 1'h1, rx, ack);
      check("ack_word", ack, 1'h0);
      tw_start();
      tw_byte({`DEV_ADDR_DIAG, 1'h1}, 1'h1, rx, ack);
      check("ack_read", ack, 1'h0);
      tw_byte(8'hFF, 1'h0, rx, ack);
      got[15:8] = rx;
      tw_byte(8'hFF, 1'h1, rx, ack);
      got[7:0] = rx;
      tw_stop();
      check("diag_word", got, exp_diag(mon[i * 4], mon[5], mon[6], cal_ext));
    end
    tx_val = 1'h0;
    for (i = 0; i < 8; i++)
    begin
      lost_raw = ~lost_raw;
      await(1, lost_raw, 2000, "lost_flag");
      repeat ($urandom_range(0, 12)) @(negedge clk_sys);
    end
    await(2, 1'h1, 20000, "laser_ready");
    fault_raw = 1'h1;
    await(0, 1'h1, 2000, "fault_set");
    await(2, exp_laser(1'h0, 1'h1), 200, "laser_fault");
    // keep the fault up long enough for the port-level timing check to see it
    repeat (8) @(negedge clk_sys);
    fault_raw = 1'h0;
    // a disable pulse well short of the minimum must leave the fault standing
    tx_val = 1'h1;
    repeat (50) @(negedge clk_sys);
    tx_val = 1'h0;
    repeat (300) @(negedge clk_sys);
    check("fault_kept", fault_line, 1'h1);
    tx_val = 1'h1;
    repeat (250) @(negedge clk_sys);
    tx_val = 1'h0;
    await(3, 1'h0, 20, "reinit");
    await(0, 1'h0, INIT + 20, "fault_cleared");
    await(3, 1'h1, INIT + 20, "init_again");
    await(2, 1'h1, 20000, "laser_back");
    reset_n = 1'h0;
    repeat (2) @(negedge clk_sys);
    check("laser_in_reset", laser_enable, 1'h0);
    reset_n = 1'h1;
    await(3, 1'h1, INIT + 20, "init_after_reset");
    await(2, 1'h1, 20000, "laser_after_reset");
    final_report();
  end
endmodule : optical_module_control_status_tb_top
